// ==== design/ibm_pkg.sv ====
// shared constants, types and state encodings of the i2c boot and master port
package ibm_pkg;

  // bus timing: standard-mode quarter bit period
  localparam int          CLK_NS      = 20;
  localparam int          QUARTER_NS  = 2500;
  localparam logic [7:0]  QUARTER_CYC = 8'((QUARTER_NS + CLK_NS - 1) / CLK_NS);

  // eeprom device addresses, write form (a2..a0 = 000 and 001)
  localparam logic [7:0]  EEP_DEV_NARROW = 8'hA0;
  localparam logic [7:0]  EEP_DEV_WIDE   = 8'hA2;
  localparam logic [7:0]  EEP_OFS_START  = 8'h00;

  // boot image layout
  localparam logic [7:0]  MARK_ID_ONLY  = 8'hC0;
  localparam logic [7:0]  MARK_LOAD     = 8'hC2;
  localparam logic [2:0]  ID_LAST       = 3'h6;
  localparam int          LEN_END_BIT   = 7;
  localparam logic [14:0] BOOT_MAX      = 15'h4000;

  // ram windows that boot content may land in
  localparam logic [15:0] CODE_LO = 16'h0000;
  localparam logic [15:0] CODE_HI = 16'h3FFF;
  localparam logic [15:0] SCR_LO  = 16'hE000;
  localparam logic [15:0] SCR_HI  = 16'hE1FF;

  // i2c_control_reg write fields
  localparam int CTL_START  = 7;
  localparam int CTL_STOP   = 6;
  localparam int CTL_LASTRD = 5;
  // i2c_control_reg read fields
  localparam int ST_DONE    = 0;
  localparam int ST_ACK     = 1;
  localparam int ST_BUSY    = 2;
  localparam int ST_BOOT    = 3;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ  = 2'h1,
    OP_STOP  = 2'h2
  } ibm_op_t;

  typedef struct packed {
    ibm_op_t    op;
    logic       with_start;
    logic       nack;
    logic [7:0] data;
  } ibm_cmd_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } ibm_ram_wr_t;

  typedef struct packed {
    logic       we;
    logic [2:0] idx;
    logic [7:0] data;
  } ibm_id_wr_t;

  typedef enum logic [3:0] {
    E_IDLE  = 4'h1,
    E_START = 4'h2,
    E_BIT   = 4'h4,
    E_STOP  = 4'h8
  } ibm_eng_st_t;

  typedef enum logic [7:0] {
    B_WAKE = 8'h01,
    B_DEVW = 8'h02,
    B_OFS  = 8'h04,
    B_DEVR = 8'h08,
    B_READ = 8'h10,
    B_TAIL = 8'h20,
    B_STOP = 8'h40,
    B_RUN  = 8'h80
  } ibm_boot_st_t;

  typedef enum logic [6:0] {
    P_MARK = 7'h01,
    P_ID   = 7'h02,
    P_LENH = 7'h04,
    P_LENL = 7'h08,
    P_ADH  = 7'h10,
    P_ADL  = 7'h20,
    P_DATA = 7'h40
  } ibm_parse_t;

endpackage

// ==== design/ibm_bit_eng.sv ====
// byte-level i2c master engine: start, write, read and stop on open-drain pins
`timescale 1ns/1ps
module ibm_bit_eng (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             cmd_valid,
  input  wire ibm_pkg::ibm_cmd_t cmd,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  done_ff,
  output logic                  ack_ff,
  output logic [7:0]            rdata_ff,
  output logic                  scl_oe_ff,
  output logic                  sda_oe_ff
);

  ibm_pkg::ibm_eng_st_t st_ff, nxt_st;
  logic [1:0] q_ff, nxt_q;
  logic [7:0] tick_ff, nxt_tick;
  logic [3:0] bit_ff, nxt_bit;
  logic [8:0] sh_ff, nxt_sh;
  logic [8:0] rx_ff, nxt_rx;
  logic       nxt_done, nxt_ack, nxt_scl, nxt_sda;
  logic [7:0] nxt_rdata;
  logic       scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff;
  logic       adv;

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_q     = q_ff;
    nxt_tick  = tick_ff;
    nxt_bit   = bit_ff;
    nxt_sh    = sh_ff;
    nxt_rx    = rx_ff;
    nxt_scl   = scl_oe_ff;
    nxt_sda   = sda_oe_ff;
    nxt_done  = 1'b0;
    nxt_ack   = ack_ff;
    nxt_rdata = rdata_ff;
    adv       = (tick_ff == 8'h00);
    if (st_ff != ibm_pkg::E_IDLE)
    begin
      // a slave stretching scl freezes the high phase until it lets go
      if (q_ff == 2'h2 && !scl_s2_ff)
        nxt_tick = ibm_pkg::QUARTER_CYC;
      else if (adv)
      begin
        nxt_tick = ibm_pkg::QUARTER_CYC;
        nxt_q    = q_ff + 2'h1;
      end
      else
        nxt_tick = tick_ff - 8'h01;
    end
    unique case (st_ff)
      ibm_pkg::E_IDLE:
        if (cmd_valid)
        begin
          nxt_q    = 2'h0;
          nxt_tick = ibm_pkg::QUARTER_CYC;
          nxt_bit  = 4'h0;
          nxt_sh   = (cmd.op == ibm_pkg::OP_READ) ? {8'hFF, cmd.nack} : {cmd.data, 1'b1};
          if (cmd.op == ibm_pkg::OP_STOP)
            nxt_st = ibm_pkg::E_STOP;
          else if (cmd.with_start)
            nxt_st = ibm_pkg::E_START;
          else
            nxt_st = ibm_pkg::E_BIT;
        end
      ibm_pkg::E_START:
      begin
        // sda released while scl low first, so a repeated start is clean
        nxt_scl = (q_ff == 2'h0) || (q_ff == 2'h3);
        nxt_sda = q_ff[1];
        if (adv && q_ff == 2'h3)
          nxt_st = ibm_pkg::E_BIT;
      end
      ibm_pkg::E_BIT:
      begin
        nxt_scl = !q_ff[1];
        // sda only moves once scl is already low, never on its falling edge
        if (q_ff != 2'h0)
          nxt_sda = !sh_ff[8];
        if (adv && q_ff == 2'h2)
          nxt_rx = {rx_ff[7:0], sda_s2_ff};
        if (adv && q_ff == 2'h3)
        begin
          if (bit_ff == 4'h8)
          begin
            nxt_done  = 1'b1;
            nxt_ack   = !rx_ff[0];
            nxt_rdata = rx_ff[8:1];
            nxt_st    = ibm_pkg::E_IDLE;
          end
          else
          begin
            nxt_bit = bit_ff + 4'h1;
            nxt_sh  = {sh_ff[7:0], 1'b1};
          end
        end
      end
      ibm_pkg::E_STOP:
      begin
        // scl low twice so sda can fall cleanly, then sda rises with scl high
        nxt_scl = !q_ff[1];
        if (q_ff != 2'h0)
          nxt_sda = (q_ff != 2'h3);
        if (adv && q_ff == 2'h3)
        begin
          nxt_done = 1'b1;
          nxt_st   = ibm_pkg::E_IDLE;
        end
      end
      default:
        nxt_st = ibm_pkg::E_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_ff     <= ibm_pkg::E_IDLE;
      q_ff      <= 2'h0;
      tick_ff   <= 8'h00;
      bit_ff    <= 4'h0;
      sh_ff     <= 9'h1FF;
      rx_ff     <= 9'h000;
      done_ff   <= 1'b0;
      ack_ff    <= 1'b0;
      rdata_ff  <= 8'h00;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
    end
    else
    begin
      st_ff     <= nxt_st;
      q_ff      <= nxt_q;
      tick_ff   <= nxt_tick;
      bit_ff    <= nxt_bit;
      sh_ff     <= nxt_sh;
      rx_ff     <= nxt_rx;
      done_ff   <= nxt_done;
      ack_ff    <= nxt_ack;
      rdata_ff  <= nxt_rdata;
      scl_oe_ff <= nxt_scl;
      sda_oe_ff <= nxt_sda;
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
    end
  end

endmodule // ibm_bit_eng

// ==== design/ibm_i2c_port.sv ====
// i2c master port: power-on eeprom boot loader plus run-time processor controller
// What this block does
// - one i2c port, boot loader and run-time controller
// - master only, never answers as slave
// - boot reads id/config bytes, then up to 16 KB
// - boot writes only code ram or scratch pad
// - processor held in reset during boot load
// - boot load only after power-on reset
// - eeprom address found by probing: a2..a0=000 first, then 001 if that gets no ack
// - processor runs transactions via control and data registers
`timescale 1ns/1ps
module ibm_i2c_port (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 por_flag,
  input  wire logic                 scl_in,
  output logic                      scl_out_ff,
  output logic                      scl_oe,
  input  wire logic                 sda_in,
  output logic                      sda_out_ff,
  output logic                      sda_oe,
  input  wire logic                 ctl_wr,
  input  wire logic [7:0]           ctl_wdata,
  input  wire logic                 data_wr,
  input  wire logic [7:0]           data_wdata,
  input  wire logic                 data_rd,
  output logic [7:0]                ctl_status_ff,
  output logic [7:0]                data_rdata_ff,
  output logic                      cpu_reset_ff,
  output logic                      boot_done_ff,
  output ibm_pkg::ibm_ram_wr_t      ram_wr_ff,
  output ibm_pkg::ibm_id_wr_t       id_wr_ff
);

  function automatic logic in_boot_ram(input logic [15:0] a);
    in_boot_ram = (a >= ibm_pkg::CODE_LO && a <= ibm_pkg::CODE_HI) ||
                  (a >= ibm_pkg::SCR_LO && a <= ibm_pkg::SCR_HI);
  endfunction

  ibm_pkg::ibm_boot_st_t st_ff, nxt_st;
  ibm_pkg::ibm_parse_t   parse_ff, nxt_parse;
  ibm_pkg::ibm_cmd_t     eng_cmd;
  ibm_pkg::ibm_ram_wr_t  nxt_ram_wr;
  ibm_pkg::ibm_id_wr_t   nxt_id_wr;
  logic        issued_ff, nxt_issued;
  logic        wide_ff, nxt_wide;
  logic        ofs_ff, nxt_ofs;
  logic        load_ff, nxt_load;
  logic [2:0]  idx_ff, nxt_idx;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] addr_ff, nxt_addr;
  logic [14:0] total_ff, nxt_total;
  logic        nxt_cpu_reset, nxt_boot_done;
  logic        start_pend_ff, nxt_start_pend;
  logic        lastrd_ff, nxt_lastrd;
  logic        busy_ff, nxt_busy;
  logic        done_ff, nxt_done;
  logic        ack_ff, nxt_ack;
  logic        rd_pend_ff, nxt_rd_pend;
  logic [7:0]  nxt_rdata;
  logic        eng_valid, eng_done, eng_ack;
  logic [7:0]  eng_rdata;
  logic        finish;

  // shared engine; the boot sequencer owns it until B_RUN
  ibm_bit_eng u_eng (
    .mclk      (mclk),
    .rstn      (rstn),
    .cmd_valid (eng_valid),
    .cmd       (eng_cmd),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .done_ff   (eng_done),
    .ack_ff    (eng_ack),
    .rdata_ff  (eng_rdata),
    .scl_oe_ff (scl_oe),
    .sda_oe_ff (sda_oe)
  );

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_parse      = parse_ff;
    nxt_issued     = issued_ff;
    nxt_wide       = wide_ff;
    nxt_ofs        = ofs_ff;
    nxt_load       = load_ff;
    nxt_idx        = idx_ff;
    nxt_cnt        = cnt_ff;
    nxt_addr       = addr_ff;
    nxt_total      = total_ff;
    nxt_cpu_reset  = cpu_reset_ff;
    nxt_boot_done  = boot_done_ff;
    nxt_ram_wr     = '0;
    nxt_id_wr      = '0;
    nxt_start_pend = start_pend_ff;
    nxt_lastrd     = lastrd_ff;
    nxt_busy       = busy_ff;
    nxt_done       = done_ff;
    nxt_ack        = ack_ff;
    nxt_rd_pend    = rd_pend_ff;
    nxt_rdata      = data_rdata_ff;
    eng_valid      = 1'b0;
    eng_cmd        = '{op: ibm_pkg::OP_WRITE, with_start: 1'b0, nack: 1'b0, data: 8'h00};
    finish         = 1'b0;
    if (st_ff != ibm_pkg::B_RUN && st_ff != ibm_pkg::B_WAKE && !issued_ff)
    begin
      eng_valid  = 1'b1;
      nxt_issued = 1'b1;
    end
    if (eng_done)
      nxt_issued = 1'b0;
    unique case (st_ff)
      ibm_pkg::B_WAKE:
        // a warm reset leaves por_flag low and skips the load
        if (por_flag)
          nxt_st = ibm_pkg::B_DEVW;
        else
        begin
          nxt_st        = ibm_pkg::B_RUN;
          nxt_cpu_reset = 1'b0;
          nxt_boot_done = 1'b1;
        end
      ibm_pkg::B_DEVW:
      begin
        // small parts answer at a2..a0=000 with one offset byte, big ones at 001
        eng_cmd.with_start = 1'b1;
        eng_cmd.data = wide_ff ? ibm_pkg::EEP_DEV_WIDE : ibm_pkg::EEP_DEV_NARROW;
        if (eng_done)
        begin
          if (eng_ack)
          begin
            nxt_st  = ibm_pkg::B_OFS;
            nxt_ofs = 1'b0;
          end
          else if (!wide_ff)
            nxt_wide = 1'b1;
          else
            nxt_st = ibm_pkg::B_STOP;
        end
      end
      ibm_pkg::B_OFS:
      begin
        eng_cmd.data = ibm_pkg::EEP_OFS_START;
        if (eng_done)
        begin
          if (wide_ff && !ofs_ff)
            nxt_ofs = 1'b1;
          else
            nxt_st = ibm_pkg::B_DEVR;
        end
      end
      ibm_pkg::B_DEVR:
      begin
        eng_cmd.with_start = 1'b1;
        eng_cmd.data = (wide_ff ? ibm_pkg::EEP_DEV_WIDE : ibm_pkg::EEP_DEV_NARROW) | 8'h01;
        if (eng_done)
          nxt_st = eng_ack ? ibm_pkg::B_READ : ibm_pkg::B_STOP;
      end
      ibm_pkg::B_READ:
      begin
        eng_cmd.op = ibm_pkg::OP_READ;
        if (eng_done)
        begin
          unique case (parse_ff)
            ibm_pkg::P_MARK:
              if (eng_rdata == ibm_pkg::MARK_ID_ONLY || eng_rdata == ibm_pkg::MARK_LOAD)
              begin
                nxt_load  = (eng_rdata == ibm_pkg::MARK_LOAD);
                nxt_idx   = 3'h0;
                nxt_parse = ibm_pkg::P_ID;
              end
              else
                finish = 1'b1;
            ibm_pkg::P_ID:
            begin
              nxt_id_wr = '{we: 1'b1, idx: idx_ff, data: eng_rdata};
              nxt_idx   = idx_ff + 3'h1;
              if (idx_ff == ibm_pkg::ID_LAST)
              begin
                if (load_ff)
                  nxt_parse = ibm_pkg::P_LENH;
                else
                  finish = 1'b1;
              end
            end
            ibm_pkg::P_LENH:
              if (eng_rdata[ibm_pkg::LEN_END_BIT])
                finish = 1'b1;
              else
              begin
                nxt_cnt[15:8] = eng_rdata;
                nxt_parse     = ibm_pkg::P_LENL;
              end
            ibm_pkg::P_LENL:
            begin
              nxt_cnt[7:0] = eng_rdata;
              if ({cnt_ff[15:8], eng_rdata} == 16'h0000)
                finish = 1'b1;
              else
                nxt_parse = ibm_pkg::P_ADH;
            end
            ibm_pkg::P_ADH:
            begin
              nxt_addr[15:8] = eng_rdata;
              nxt_parse      = ibm_pkg::P_ADL;
            end
            ibm_pkg::P_ADL:
            begin
              nxt_addr[7:0] = eng_rdata;
              nxt_parse     = ibm_pkg::P_DATA;
            end
            ibm_pkg::P_DATA:
            begin
              // bytes aimed outside the two windows are read and dropped
              nxt_ram_wr = '{we: in_boot_ram(addr_ff), addr: addr_ff, data: eng_rdata};
              nxt_addr   = addr_ff + 16'h0001;
              nxt_cnt    = cnt_ff - 16'h0001;
              nxt_total  = total_ff + 15'h0001;
              if (total_ff + 15'h0001 == ibm_pkg::BOOT_MAX)
                finish = 1'b1;
              else if (cnt_ff == 16'h0001)
                nxt_parse = ibm_pkg::P_LENH;
            end
            default:
              finish = 1'b1;
          endcase
          if (finish)
            nxt_st = ibm_pkg::B_TAIL;
        end
      end
      ibm_pkg::B_TAIL:
      begin
        // one nacked dummy read so the eeprom lets go of sda before stop
        eng_cmd.op   = ibm_pkg::OP_READ;
        eng_cmd.nack = 1'b1;
        if (eng_done)
          nxt_st = ibm_pkg::B_STOP;
      end
      ibm_pkg::B_STOP:
      begin
        eng_cmd.op = ibm_pkg::OP_STOP;
        if (eng_done)
        begin
          nxt_st        = ibm_pkg::B_RUN;
          nxt_cpu_reset = 1'b0;
          nxt_boot_done = 1'b1;
        end
      end
      ibm_pkg::B_RUN:
      begin
        // strobes that arrive while a byte is on the bus are dropped
        if (eng_done)
        begin
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
          nxt_ack  = eng_ack;
          if (rd_pend_ff)
            nxt_rdata = eng_rdata;
        end
        else if (!busy_ff)
        begin
          if (ctl_wr)
          begin
            nxt_start_pend = ctl_wdata[ibm_pkg::CTL_START];
            nxt_lastrd     = ctl_wdata[ibm_pkg::CTL_LASTRD];
            if (ctl_wdata[ibm_pkg::CTL_STOP])
            begin
              eng_valid   = 1'b1;
              eng_cmd.op  = ibm_pkg::OP_STOP;
              nxt_rd_pend = 1'b0;
            end
          end
          else if (data_wr)
          begin
            eng_valid          = 1'b1;
            eng_cmd.with_start = start_pend_ff;
            eng_cmd.data       = data_wdata;
            nxt_start_pend     = 1'b0;
            nxt_rd_pend        = 1'b0;
          end
          else if (data_rd)
          begin
            eng_valid    = 1'b1;
            eng_cmd.op   = ibm_pkg::OP_READ;
            eng_cmd.nack = lastrd_ff;
            nxt_rd_pend  = 1'b1;
          end
          if (eng_valid)
          begin
            nxt_busy = 1'b1;
            nxt_done = 1'b0;
          end
        end
      end
      default:
        nxt_st = ibm_pkg::B_RUN;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_ff         <= ibm_pkg::B_WAKE;
      parse_ff      <= ibm_pkg::P_MARK;
      issued_ff     <= 1'b0;
      wide_ff       <= 1'b0;
      ofs_ff        <= 1'b0;
      load_ff       <= 1'b0;
      idx_ff        <= 3'h0;
      cnt_ff        <= 16'h0000;
      addr_ff       <= 16'h0000;
      total_ff      <= 15'h0000;
      cpu_reset_ff  <= 1'b1;
      boot_done_ff  <= 1'b0;
      ram_wr_ff     <= '0;
      id_wr_ff      <= '0;
      start_pend_ff <= 1'b0;
      lastrd_ff     <= 1'b0;
      busy_ff       <= 1'b0;
      done_ff       <= 1'b0;
      ack_ff        <= 1'b0;
      rd_pend_ff    <= 1'b0;
      data_rdata_ff <= 8'h00;
      ctl_status_ff <= 8'h00;
      scl_out_ff    <= 1'b0;
      sda_out_ff    <= 1'b0;
    end
    else
    begin
      st_ff         <= nxt_st;
      parse_ff      <= nxt_parse;
      issued_ff     <= nxt_issued;
      wide_ff       <= nxt_wide;
      ofs_ff        <= nxt_ofs;
      load_ff       <= nxt_load;
      idx_ff        <= nxt_idx;
      cnt_ff        <= nxt_cnt;
      addr_ff       <= nxt_addr;
      total_ff      <= nxt_total;
      cpu_reset_ff  <= nxt_cpu_reset;
      boot_done_ff  <= nxt_boot_done;
      ram_wr_ff     <= nxt_ram_wr;
      id_wr_ff      <= nxt_id_wr;
      start_pend_ff <= nxt_start_pend;
      lastrd_ff     <= nxt_lastrd;
      busy_ff       <= nxt_busy;
      done_ff       <= nxt_done;
      ack_ff        <= nxt_ack;
      rd_pend_ff    <= nxt_rd_pend;
      data_rdata_ff <= nxt_rdata;
      ctl_status_ff <= {4'h0, !nxt_boot_done, nxt_busy, nxt_ack, nxt_done};
      // open-drain: the pin only ever pulls low
      scl_out_ff    <= 1'b0;
      sda_out_ff    <= 1'b0;
    end
  end

endmodule // ibm_i2c_port

// ==== dv/ibm_i2c_port_asserts.sv ====
// concurrent checks on the ports of the i2c boot and master port
`timescale 1ns/1ps
module ibm_i2c_port_asserts (
  input wire logic                 mclk,
  input wire logic                 rstn,
  input wire logic                 por_flag,
  input wire logic                 scl_out_ff,
  input wire logic                 scl_oe,
  input wire logic                 sda_out_ff,
  input wire logic                 sda_oe,
  input wire logic                 ctl_wr,
  input wire logic                 data_wr,
  input wire logic [7:0]           ctl_status_ff,
  input wire logic                 cpu_reset_ff,
  input wire logic                 boot_done_ff,
  input wire ibm_pkg::ibm_ram_wr_t ram_wr_ff,
  input wire ibm_pkg::ibm_id_wr_t  id_wr_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic busy;
  logic done;
  assign busy = ctl_status_ff[ibm_pkg::ST_BUSY];
  assign done = ctl_status_ff[ibm_pkg::ST_DONE];

  a_cpu_held: assert property (ctl_status_ff[ibm_pkg::ST_BOOT] |-> cpu_reset_ff)
    else $error("processor free while boot runs");
  a_cpu_free: assert property ($fell(cpu_reset_ff) |-> boot_done_ff)
    else $error("processor freed before handover");
  a_handover_ok: assert property (boot_done_ff |-> !cpu_reset_ff && !ctl_status_ff[3])
    else $error("handover left processor in reset");
  a_por_boots: assert property ($rose(rstn) && por_flag |=> !boot_done_ff [*8])
    else $error("power-on reset skipped boot");
  a_warm_skip: assert property ($rose(rstn) && !por_flag |-> ##[1:3] boot_done_ff)
    else $error("warm reset started a boot");
  a_ram_window: assert property (ram_wr_ff.we |-> ram_wr_ff.addr <= ibm_pkg::CODE_HI ||
    (ram_wr_ff.addr >= ibm_pkg::SCR_LO && ram_wr_ff.addr <= ibm_pkg::SCR_HI))
    else $error("boot write outside ram windows");
  a_id_range: assert property (id_wr_ff.we |-> id_wr_ff.idx <= ibm_pkg::ID_LAST)
    else $error("id index out of range");
  a_boot_only: assert property (boot_done_ff |-> !ram_wr_ff.we && !id_wr_ff.we)
    else $error("boot write after handover");
  a_open_drain: assert property (!scl_out_ff && !sda_out_ff)
    else $error("pin driven high");
  a_idle_quiet: assert property (boot_done_ff && !busy && !scl_oe |-> !sda_oe)
    else $error("sda pulled while idle");
  a_take_cmd: assert property (boot_done_ff && !busy && data_wr && !ctl_wr |=> busy && !done)
    else $error("data write not taken");
  a_done_ends: assert property ($rose(done) |-> !busy && $past(busy))
    else $error("done without busy phase");

  c_id_wr: cover property (id_wr_ff.we);
  c_ram_wr: cover property (ram_wr_ff.we);
  c_boot_end: cover property ($rose(boot_done_ff));
  c_cmd_done: cover property ($rose(done));
endmodule // ibm_i2c_port_asserts

// ==== dv/ibm_eep_model.sv ====
// behavioural serial eeprom on the far side of the i2c port
`timescale 1ns/1ps
module ibm_eep_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic slow,
  output logic      scl_oe,
  output logic      sda_oe
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, tx, ptr, first_dev;
  logic       sel, rdm, mack, adr_ph, ofs_ph;
  int         cnt, n_addr;
  initial
  begin
    {scl_oe, sda_oe, sel, rdm, mack, adr_ph, ofs_ph} = 7'h00;
    {sh, tx, ptr, first_dev} = 32'h0000_0000;
    cnt = 0;
    n_addr = 0;
  end
  // start and stop are sda edges while scl is high
  always @(negedge sda)
    if (scl)
    begin
      cnt = 0;
      adr_ph = 1'b1;
      rdm = 1'b0;
    end
  always @(posedge sda)
    if (scl)
    begin
      sel = 1'b0;
      rdm = 1'b0;
    end
  always @(posedge scl)
  begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else mack = !sda;
    cnt = cnt + 1;
  end
  always @(negedge scl)
  begin
    if (cnt == 8 && !rdm)
    begin
      if (adr_ph)
      begin
        sel = (sh[7:1] == 7'h50);
        rdm = sel & sh[0];
        ofs_ph = sel & !sh[0];
        adr_ph = 1'b0;
        n_addr = n_addr + 1;
        if (n_addr == 1) first_dev = sh;
      end
      else if (ofs_ph)
      begin
        ptr = sh;
        ofs_ph = 1'b0;
      end
      else if (sel)
      begin
        mem[ptr] = sh;
        ptr = ptr + 8'h01;
      end
      sda_oe = sel;
    end
    else if (cnt == 8) sda_oe = 1'b0;
    else if (cnt == 9)
    begin
      cnt = 0;
      sda_oe = 1'b0;
      if (rdm && mack)
      begin
        tx = mem[ptr];
        ptr = ptr + 8'h01;
        sda_oe = !tx[7];
      end
      else rdm = 1'b0;
      // slow mode stretches the clock after every acknowledge
      if (slow)
      begin
        scl_oe = 1'b1;
        #1000 scl_oe = 1'b0;
      end
    end
    else if (rdm && cnt > 0) sda_oe = !tx[7 - cnt];
  end
endmodule // ibm_eep_model

// ==== dv/ibm_i2c_port_tb.sv ====
// self-checking bench of the i2c boot and master port
`timescale 1ns/1ps
module ibm_i2c_port_tb;
  logic mclk = 1'b0, rstn = 1'b0, por_flag = 1'b1, slow = 1'b0;
  logic ctl_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0, want = 1'b0, rd_mode = 1'b0;
  logic [7:0] ctl_wdata = 8'h00, data_wdata = 8'h00, d1;
  logic scl_oe, sda_oe, scl_out_ff, sda_out_ff, m_scl_oe, m_sda_oe, cpu_reset_ff, boot_done_ff;
  logic [7:0] ctl_status_ff, data_rdata_ff;
  ibm_pkg::ibm_ram_wr_t ram_wr_ff;
  ibm_pkg::ibm_id_wr_t  id_wr_ff;
  wire scl_w = !(scl_oe | m_scl_oe);
  wire sda_w = !(sda_oe | m_sda_oe);
  logic [25:0] exp_q[$];
  int err_total = 0, checks_done = 0, i, n, n_seen;
  integer seed = 32'h2C54;
  always #10 mclk = ~mclk;

  ibm_i2c_port ibm_i2c_port_i (.mclk, .rstn, .por_flag, .scl_in(scl_w), .scl_out_ff, .scl_oe,
    .sda_in(sda_w), .sda_out_ff, .sda_oe, .ctl_wr, .ctl_wdata, .data_wr, .data_wdata,
    .data_rd, .ctl_status_ff, .data_rdata_ff, .cpu_reset_ff, .boot_done_ff, .ram_wr_ff,
    .id_wr_ff);
  ibm_eep_model ibm_eep_model_i (.scl(scl_w), .sda(sda_w), .slow, .scl_oe(m_scl_oe),
    .sda_oe(m_sda_oe));

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic take(input string nm, input logic [1:0] k, input logic [15:0] a,
                      input logic [7:0] d);
    logic [25:0] e;
    e = 26'h0;
    checks_done++;
    if (exp_q.size() > 0) e = exp_q.pop_front();
    if (e !== {k, a, d})
    begin
      $display("Error %s expected %h seen %h", nm, e, {k, a, d});
      err_total++;
    end
  endtask
  // every ram and id write, and each command done while want is set, is matched against the oldest note
  always @(posedge mclk)
  begin
    if (ram_wr_ff.we === 1'b1) take("ram", 2'h2, ram_wr_ff.addr, ram_wr_ff.data);
    if (id_wr_ff.we === 1'b1) take("id", 2'h1, 16'(id_wr_ff.idx), id_wr_ff.data);
    if ($rose(ctl_status_ff[ibm_pkg::ST_DONE]) && want)
      take("cmd", 2'h3, 16'h0000, rd_mode ? data_rdata_ff : 8'(ctl_status_ff[1]));
  end
  // w: 0 control write, 1 data write, 2 data read
  task automatic cmd(input logic [1:0] w, input logic [7:0] v, input logic [7:0] e,
                     input logic c);
    int k;
    if (c) exp_q.push_back({2'h3, 16'h0000, e});
    want = c;
    rd_mode = (w == 2'h2);
    @(negedge mclk);
    ctl_wr = (w == 2'h0);
    data_wr = (w == 2'h1);
    data_rd = (w == 2'h2);
    ctl_wdata = v;
    data_wdata = v;
    @(negedge mclk);
    {ctl_wr, data_wr, data_rd} = 3'h0;
    if (w != 2'h0 || v[ibm_pkg::CTL_STOP])
    begin
      for (k = 0; k < 30000 && ctl_status_ff[ibm_pkg::ST_DONE] !== 1'b1; k++) @(negedge mclk);
      if (k == 30000)
      begin
        err_total++;
        test_done();
      end
      // one more edge so the monitor still sees this call's note flags
      @(negedge mclk);
    end
  endtask

  initial
  begin
    for (i = 0; i < 256; i++) ibm_eep_model_i.mem[i] = 8'h80;
    ibm_eep_model_i.mem[0] = ibm_pkg::MARK_LOAD;
    for (i = 1; i < 8; i++)
    begin
      ibm_eep_model_i.mem[i] = 8'($random(seed));
      exp_q.push_back({2'h1, 16'(i - 1), ibm_eep_model_i.mem[i]});
    end
    // two bytes at 3FFF: the second falls outside the code window
    ibm_eep_model_i.mem[8] = 8'h00;
    ibm_eep_model_i.mem[9] = 8'h02;
    ibm_eep_model_i.mem[10] = 8'h3F;
    ibm_eep_model_i.mem[11] = 8'hFF;
    ibm_eep_model_i.mem[12] = 8'($random(seed));
    d1 = 8'($random(seed));
    ibm_eep_model_i.mem[13] = d1;
    exp_q.push_back({2'h2, 16'h3FFF, ibm_eep_model_i.mem[12]});
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    for (n = 0; n < 150000 && boot_done_ff !== 1'b1; n++) @(negedge mclk);
    chk_v("boot_done", 8'h01, 8'(boot_done_ff));
    chk_v("cpu_reset", 8'h00, 8'(cpu_reset_ff));
    chk_v("first_dev", ibm_pkg::EEP_DEV_NARROW, ibm_eep_model_i.first_dev);
    chk_v("pending", 8'h00, 8'(exp_q.size()));
    if (n == 150000)
    begin
      err_total++;
      test_done();
    end
    n_seen = ibm_eep_model_i.n_addr;
    por_flag = 1'b0;
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    chk_v("warm_done", 8'h01, 8'(boot_done_ff));
    chk_v("warm_cpu", 8'h00, 8'(cpu_reset_ff));
    chk_v("warm_addr", 8'(n_seen), 8'(ibm_eep_model_i.n_addr));
    slow = 1'b1;
    cmd(2'h0, 8'h80, 8'h00, 1'b0);
    cmd(2'h1, ibm_pkg::EEP_DEV_NARROW, 8'h01, 1'b1);
    cmd(2'h1, 8'h0D, 8'h01, 1'b1);
    cmd(2'h0, 8'h80, 8'h00, 1'b0);
    cmd(2'h1, ibm_pkg::EEP_DEV_NARROW | 8'h01, 8'h01, 1'b1);
    cmd(2'h0, 8'h20, 8'h00, 1'b0);
    cmd(2'h2, 8'h00, d1, 1'b1);
    cmd(2'h0, 8'h40, 8'h00, 1'b0);
    repeat (4) @(negedge mclk);
    chk_v("scl_idle", 8'h01, 8'(scl_w));
    chk_v("sda_idle", 8'h01, 8'(sda_w));
    chk_v("left", 8'h00, 8'(exp_q.size()));
    test_done();
  end
endmodule // ibm_i2c_port_tb

bind ibm_i2c_port ibm_i2c_port_asserts ibm_i2c_port_asserts_i (.mclk, .rstn, .por_flag,
  .scl_out_ff, .scl_oe, .sda_out_ff, .sda_oe, .ctl_wr, .data_wr, .ctl_status_ff,
  .cpu_reset_ff, .boot_done_ff, .ram_wr_ff, .id_wr_ff);
